// *** sipr_defines.svh ***
// constants for the status indicator and pin route block
`ifndef SIPR_DEFINES_SVH
`define SIPR_DEFINES_SVH
// timing
`define SIPR_CLK_HZ       25000000
`define SIPR_FLASH_MS     250
`define SIPR_FLASH_CYC    (`SIPR_CLK_HZ / 1000 * `SIPR_FLASH_MS)
`define SIPR_FLASH_CW     23
// register byte offsets
`define SIPR_OFS_CTRL     4'h0
`define SIPR_OFS_STATUS   4'h4
`define SIPR_OFS_IRQ_STAT 4'h8
`define SIPR_OFS_IRQ_MASK 4'hC
// reset values
`define SIPR_CTRL_RST     4'h3
`define SIPR_MASK_RST     6'h00
// status register field positions
`define SIPR_ST_SYS       0
`define SIPR_ST_STRAP_OK  4
`define SIPR_ST_STRAP     5
`define SIPR_ST_SYS_LED   6
`define SIPR_ST_CH0_LED   8
`define SIPR_ST_CH1_LED   10
// event bit positions
`define SIPR_EV_CH0_ERR   0
`define SIPR_EV_CH1_ERR   1
`define SIPR_EV_CH0_OVF   2
`define SIPR_EV_CH1_OVF   3
`define SIPR_EV_FAULT     4
`define SIPR_EV_LINK      5
`define SIPR_EV_W         6
`endif

// *** sipr_pkg.sv ***
// types shared by the status indicator and pin route block
package sipr_pkg;
  // dual-colour indicator drive
  typedef struct packed {
    logic red;
    logic green;
  } sipr_led_t;

  // status reported by one controller channel
  typedef struct packed {
    logic started;
    logic connected;
    logic ctrl_error;
    logic bus_error;
    logic overflow;
  } sipr_chan_status_t;

  // system indicator sequence
  typedef enum logic [3:0] {
    S_INIT  = 4'h1,
    S_FLASH = 4'h2,
    S_RUN   = 4'h4,
    S_FAULT = 4'h8
  } sipr_sys_t;

  // flash prescaler state
  typedef struct packed {
    logic [22:0] cnt;
    logic        phase;
    logic        tick;
  } sipr_flash_st_t;
endpackage

// *** sipr_flash_gen.sv ***
// flash prescaler: slow phase square wave and its toggle pulse
`timescale 1ns/1ps
`include "sipr_defines.svh"
module sipr_flash_gen #(
  parameter int FLASH_CYCLES = `SIPR_FLASH_CYC
) (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic nrst_i,
  // flash timing
  output logic      phase_o,
  output logic      tick_o
);
  import sipr_pkg::*;

  sipr_flash_st_t s;
  sipr_flash_st_t next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt == `SIPR_FLASH_CW'(FLASH_CYCLES - 1)) begin
      next_s.cnt   = '0;
      next_s.phase = ~s.phase;
      next_s.tick  = 1'b1;
    end else begin
      next_s.cnt = s.cnt + `SIPR_FLASH_CW'(1);
    end
  end

  // state register
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign phase_o = s.phase;
  assign tick_o  = s.tick;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  a_tick_toggles: assert property (tick_o |-> phase_o != $past(phase_o))
    else $error("tick without phase change");
endmodule

// *** sipr_chan_led.sv ***
// per-channel indicator decode with fixed precedence
`timescale 1ns/1ps
module sipr_chan_led (
  // clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  nrst_i,
  // channel status and flash phase
  input  sipr_pkg::sipr_chan_status_t status_i,
  input  wire logic                  phase_i,
  // indicator drive
  output sipr_pkg::sipr_led_t        led_o
);
  import sipr_pkg::*;

  sipr_led_t s;
  sipr_led_t next_s;

  always_comb begin
    next_s = '0;
    if (!status_i.connected) begin
      next_s = '0;
    end else if (!status_i.started) begin
      next_s.red   = phase_i;
      next_s.green = ~phase_i;
    end else if (status_i.ctrl_error) begin
      next_s.red = 1'b1;
    end else if (status_i.bus_error || status_i.overflow) begin
      next_s.red = phase_i;
    end else begin
      next_s.green = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign led_o = s;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  a_chan_off: assert property (!status_i.connected |=> led_o == 2'h0)
    else $error("disconnected channel lit");
  a_chan_alternate: assert property (status_i.connected && !status_i.started
    |=> led_o.red == $past(phase_i) && led_o.green != $past(phase_i))
    else $error("unstarted channel not alternating");
  a_chan_err_red: assert property (status_i.connected && status_i.started
    && status_i.ctrl_error |=> led_o == 2'h2)
    else $error("controller error not red");
  a_chan_ovf_flash: assert property (status_i.connected && status_i.started
    && !status_i.ctrl_error && status_i.overflow |=> !led_o.green
    && led_o.red == $past(phase_i))
    else $error("overflow not flashing red");
  a_chan_green: assert property (status_i.connected && status_i.started
    && !status_i.ctrl_error && !status_i.bus_error && !status_i.overflow
    |=> led_o == 2'h1)
    else $error("healthy channel not green");
  c_chan_alt: cover property (status_i.connected && !status_i.started ##1 !led_o.green);
endmodule

// *** sipr_top.sv ***
// status indicator and pin route top: leds, strap routing, register slave
//
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`include "sipr_defines.svh"
module sipr_top #(
  parameter int FLASH_CYCLES = `SIPR_FLASH_CYC
) (
  // clock and reset
  input  wire logic                         clock_i,
  input  wire logic                         nrst_i,
  // system status inputs
  input  wire logic                         init_done_i,
  input  wire logic                         host_link_i,
  input  wire logic                         usb_active_i,
  input  wire logic                         power_fault_i,
  input  wire logic                         sys_error_i,
  // channel status inputs
  input  sipr_pkg::sipr_chan_status_t [1:0] chan_status_i,
  // pin routing
  input  wire logic                         route_select_strap_i,
  input  wire logic [1:0]                   ctrl_tx_i,
  output logic [1:0]                        ctrl_rx_o,
  output logic [1:0]                        xcvr_tx_o,
  input  wire logic [1:0]                   xcvr_rx_i,
  output logic                              chan0_tx_alt_pin_o,
  input  wire logic                         chan0_rx_alt_pin_i,
  output logic                              chan1_tx_alt_pin_o,
  input  wire logic                         chan1_rx_alt_pin_i,
  // indicators
  output sipr_pkg::sipr_led_t               system_status_led_o,
  output sipr_pkg::sipr_led_t               channel0_status_led_o,
  output sipr_pkg::sipr_led_t               channel1_status_led_o,
  // avalon-mm slave
  input  wire logic [3:0]                   avs_address_i,
  input  wire logic                         avs_read_i,
  input  wire logic                         avs_write_i,
  input  wire logic [31:0]                  avs_writedata_i,
  input  wire logic [3:0]                   avs_byteenable_i,
  output logic [31:0]                       avs_readdata_o,
  output logic                              avs_waitrequest_o,
  // interrupt
  output logic                              irq_o
);
  import sipr_pkg::*;

  // whole state of the top level
  typedef struct packed {
    sipr_sys_t              system_status_led;
    logic [3:0]             flash_cnt;
    sipr_led_t              sys_led;
    logic                   strap_done;
    logic                   strap;
    logic [1:0]             xcvr_tx;
    logic [1:0]             alt_tx;
    logic [1:0]             ctrl_rx;
    logic                   waitreq;
    logic [31:0]            rdata;
    logic [3:0]             flashes;
    logic [`SIPR_EV_W-1:0]  irq_stat;
    logic [`SIPR_EV_W-1:0]  irq_mask;
    logic [`SIPR_EV_W-1:0]  ev_prev;
    logic                   irq;
  } sipr_top_st_t;

  sipr_top_st_t           s;
  sipr_top_st_t           next_s;
  logic                   phase;
  logic                   tick;
  logic                   fault;
  logic [`SIPR_EV_W-1:0]  ev_now;
  logic [`SIPR_EV_W-1:0]  ev_rise;
  logic [`SIPR_EV_W-1:0]  w1c;
  logic [31:0]            rd_mux;
  sipr_led_t [1:0]        chan_led;

  // register hit, word aligned byte address
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
    hit = (addr == ofs);
  endfunction

  // shared flash timing
  sipr_flash_gen #(
    .FLASH_CYCLES (FLASH_CYCLES)
  ) u_flash (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .phase_o (phase),
    .tick_o  (tick)
  );

  for (genvar i = 0; i < 2; i++) begin : g_chan
    sipr_chan_led u_led (
      .clock_i  (clock_i),
      .nrst_i   (nrst_i),
      .status_i (chan_status_i[i]),
      .phase_i  (phase),
      .led_o    (chan_led[i])
    );
  end

  // event sources for the interrupt status
  assign fault = power_fault_i | sys_error_i;
  assign ev_now[`SIPR_EV_CH0_ERR] = chan_status_i[0].ctrl_error;
  assign ev_now[`SIPR_EV_CH1_ERR] = chan_status_i[1].ctrl_error;
  assign ev_now[`SIPR_EV_CH0_OVF] = chan_status_i[0].overflow | chan_status_i[0].bus_error;
  assign ev_now[`SIPR_EV_CH1_OVF] = chan_status_i[1].overflow | chan_status_i[1].bus_error;
  assign ev_now[`SIPR_EV_FAULT]   = fault;
  assign ev_now[`SIPR_EV_LINK]    = host_link_i;
  assign ev_rise = ev_now & ~s.ev_prev;
  // write-one-to-clear only on the accepted write cycle
  assign w1c = (!s.waitreq && avs_write_i && avs_byteenable_i[0]
               && hit(avs_address_i, `SIPR_OFS_IRQ_STAT))
               ? avs_writedata_i[`SIPR_EV_W-1:0] : '0;

  // read mux, unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(avs_address_i, `SIPR_OFS_CTRL)) begin
      rd_mux[3:0] = s.flashes;
    end else if (hit(avs_address_i, `SIPR_OFS_STATUS)) begin
      rd_mux[`SIPR_ST_SYS +: 4]     = s.system_status_led;
      rd_mux[`SIPR_ST_STRAP_OK]     = s.strap_done;
      rd_mux[`SIPR_ST_STRAP]        = s.strap;
      rd_mux[`SIPR_ST_SYS_LED +: 2] = s.sys_led;
      rd_mux[`SIPR_ST_CH0_LED +: 2] = chan_led[0];
      rd_mux[`SIPR_ST_CH1_LED +: 2] = chan_led[1];
    end else if (hit(avs_address_i, `SIPR_OFS_IRQ_STAT)) begin
      rd_mux[`SIPR_EV_W-1:0] = s.irq_stat;
    end else if (hit(avs_address_i, `SIPR_OFS_IRQ_MASK)) begin
      rd_mux[`SIPR_EV_W-1:0] = s.irq_mask;
    end
  end

  // next state
  always_comb begin
    next_s = s;

    // system indicator sequence; fault overrides every state
    case (s.system_status_led)
      S_INIT: begin
        if (init_done_i) begin
          next_s.system_status_led       = S_FLASH;
          next_s.flash_cnt = 4'h0;
        end
      end
      S_FLASH: begin
        if (tick && !phase && s.flash_cnt != s.flashes) begin
          next_s.flash_cnt = s.flash_cnt + 4'h1;
        end
        if (s.flash_cnt == s.flashes && host_link_i) begin
          next_s.system_status_led = S_RUN;
        end
      end
      S_RUN: begin
        // losing the host link drops back to flashing
        if (!host_link_i) begin
          next_s.system_status_led = S_FLASH;
        end
      end
      S_FAULT: begin
        // restart the sequence once the fault clears
        if (!fault) begin
          next_s.system_status_led = S_INIT;
        end
      end
      default: begin
        next_s.system_status_led = S_INIT;
      end
    endcase
    if (fault) begin
      next_s.system_status_led = S_FAULT;
    end

    // system led drive from the current state
    case (s.system_status_led)
      S_INIT:  next_s.sys_led = 2'h2;
      S_FLASH: next_s.sys_led = {1'b0, phase};
      S_RUN:   next_s.sys_led = {1'b0, usb_active_i ? phase : 1'b1};
      S_FAULT: next_s.sys_led = 2'h0;
      default: next_s.sys_led = 2'h0;
    endcase

    // strap caught once, first edge after release
    if (!s.strap_done) begin
      next_s.strap_done = 1'b1;
      next_s.strap      = route_select_strap_i;
    end
    // lines idle recessive until the strap is known
    if (!s.strap_done) begin
      next_s.xcvr_tx = 2'h3;
      next_s.alt_tx  = 2'h3;
      next_s.ctrl_rx = 2'h3;
    end else if (s.strap) begin
      next_s.xcvr_tx = ctrl_tx_i;
      next_s.alt_tx  = 2'h3;
      next_s.ctrl_rx = xcvr_rx_i;
    end else begin
      next_s.xcvr_tx = 2'h3;
      next_s.alt_tx  = ctrl_tx_i;
      next_s.ctrl_rx = {chan1_rx_alt_pin_i, chan0_rx_alt_pin_i};
    end

    // bus handshake: every request waits exactly one cycle
    next_s.waitreq = 1'b1;
    if (s.waitreq && (avs_read_i || avs_write_i)) begin
      next_s.waitreq = 1'b0;
    end
    if (s.waitreq && avs_read_i) begin
      next_s.rdata = rd_mux;
    end
    // writes land on the edge after the wait, while waitrequest is low
    if (!s.waitreq && avs_write_i && avs_byteenable_i[0]) begin
      if (hit(avs_address_i, `SIPR_OFS_CTRL)) begin
        next_s.flashes = avs_writedata_i[3:0];
      end
      if (hit(avs_address_i, `SIPR_OFS_IRQ_MASK)) begin
        next_s.irq_mask = avs_writedata_i[`SIPR_EV_W-1:0];
      end
    end

    // sticky events: a new event beats a same-cycle clear
    next_s.ev_prev  = ev_now;
    next_s.irq_stat = (s.irq_stat & ~w1c) | ev_rise;
    next_s.irq      = |(next_s.irq_stat & next_s.irq_mask);
  end

  // state register
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s          <= '0;
      s.system_status_led      <= S_INIT;
      s.sys_led  <= 2'h2;
      s.xcvr_tx  <= 2'h3;
      s.alt_tx   <= 2'h3;
      s.ctrl_rx  <= 2'h3;
      s.waitreq  <= 1'b1;
      s.flashes  <= `SIPR_CTRL_RST;
      s.irq_mask <= `SIPR_MASK_RST;
    end else begin
      s <= next_s;
    end
  end

  // outputs, each straight from a flip-flop
  assign system_status_led_o   = s.sys_led;
  assign channel0_status_led_o = chan_led[0];
  assign channel1_status_led_o = chan_led[1];
  assign xcvr_tx_o             = s.xcvr_tx;
  assign chan0_tx_alt_pin_o    = s.alt_tx[0];
  assign chan1_tx_alt_pin_o    = s.alt_tx[1];
  assign ctrl_rx_o             = s.ctrl_rx;
  assign avs_readdata_o        = s.rdata;
  assign avs_waitrequest_o     = s.waitreq;
  assign irq_o                 = s.irq;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  a_init_red: assert property (s.system_status_led == S_INIT |=> system_status_led_o == 2'h2)
    else $error("system led not red in init");
  a_fault_dark: assert property (fault |-> ##2 system_status_led_o == 2'h0)
    else $error("system led lit after fault");
  a_run_green: assert property (s.system_status_led == S_RUN && !usb_active_i
    |=> system_status_led_o == 2'h1)
    else $error("linked system led not steady green");
  a_usb_flash: assert property (s.system_status_led == S_RUN && usb_active_i
    |=> system_status_led_o.green == $past(phase) && !system_status_led_o.red)
    else $error("usb traffic not flashing green");
  a_flash_before: assert property (s.system_status_led == S_FLASH && s.flash_cnt != s.flashes
    |=> s.system_status_led != S_RUN)
    else $error("green before startup flashes done");
  a_strap_held: assert property (s.strap_done |=> $stable(s.strap) && s.strap_done)
    else $error("strap changed after capture");
  a_route_board: assert property (s.strap_done && s.strap
    |=> xcvr_tx_o == $past(ctrl_tx_i) && chan0_tx_alt_pin_o && chan1_tx_alt_pin_o
    && ctrl_rx_o == $past(xcvr_rx_i))
    else $error("strap present but not on transceiver");
  a_route_alt: assert property (s.strap_done && !s.strap
    |=> {chan1_tx_alt_pin_o, chan0_tx_alt_pin_o} == $past(ctrl_tx_i)
    && xcvr_tx_o == 2'h3)
    else $error("strap absent but not on alt pins");
  a_bus_ack: assert property (avs_waitrequest_o && (avs_read_i || avs_write_i)
    |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("waitrequest not one cycle");
  a_irq_level: assert property (irq_o == |(s.irq_stat & s.irq_mask))
    else $error("irq output mismatch");

  // system sequence: init hold, fault entry, link before green
  a_init_hold: assert property (s.system_status_led == S_INIT && !init_done_i && !fault
    |=> s.system_status_led == S_INIT)
    else $error("system left init early");
  a_fault_enter: assert property (fault |=> s.system_status_led == S_FAULT)
    else $error("fault state not entered");
  a_run_linked: assert property (s.system_status_led == S_RUN |-> $past(host_link_i))
    else $error("run state without host link");
  // flashes done and host linked must move on to green
  a_flash_done: assert property (s.system_status_led == S_FLASH && s.flash_cnt == s.flashes
    && host_link_i && !fault |=> s.system_status_led == S_RUN)
    else $error("no green after startup flashes");
  // strap caught on the first edge after release
  a_strap_catch: assert property (!s.strap_done |=> s.strap_done
    && s.strap == $past(route_select_strap_i))
    else $error("strap not caught after reset");
  // no line may toggle before the route is known
  a_route_idle: assert property (!s.strap_done |=> xcvr_tx_o == 2'h3
    && ctrl_rx_o == 2'h3 && chan0_tx_alt_pin_o && chan1_tx_alt_pin_o)
    else $error("lines active before strap known");
  // read data only move on a read, at the edge that ends its wait cycle
  a_rdata_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data changed without a read");
  // a new event is kept even when a clear lands with it
  a_event_sticky: assert property ($rose(chan_status_i[0].ctrl_error)
    |=> s.irq_stat[`SIPR_EV_CH0_ERR])
    else $error("controller error event lost");
  a_fault_event: assert property ($rose(fault) |=> s.irq_stat[`SIPR_EV_FAULT])
    else $error("fault event lost");
  a_link_event: assert property ($rose(host_link_i) |=> s.irq_stat[`SIPR_EV_LINK])
    else $error("host link event lost");

  c_reach_run: cover property (s.system_status_led == S_FLASH ##1 s.system_status_led == S_RUN);
  c_fault_seen: cover property (s.system_status_led == S_FAULT);
  c_irq_raised: cover property (!irq_o ##1 irq_o);
  c_read_done: cover property (avs_read_i && !avs_waitrequest_o);
endmodule

// *** sipr_far_model.sv ***
// far side of the pin route: on-board transceivers and backplane transceivers
`timescale 1ns/1ps
module sipr_far_model (
  // transmit lines from the block
  input  wire logic [1:0] xcvr_tx_i,
  input  wire logic [1:0] alt_tx_i,
  // other nodes holding each bus dominant
  input  wire logic [1:0] bus_dom_i,
  input  wire logic [1:0] alt_dom_i,
  // receive lines back to the block
  output logic [1:0]      xcvr_rx_o,
  output logic [1:0]      alt_rx_o
);
  // wired-and bus: own echo unless another node pulls low
  // the two buses are loaded differently so a wrong route shows up
  assign xcvr_rx_o = xcvr_tx_i & ~bus_dom_i;
  assign alt_rx_o  = alt_tx_i & ~alt_dom_i;
endmodule

// *** sipr_top_tb.sv ***
// self-checking bench for the status indicator and pin route top
`timescale 1ns/1ps
`include "sipr_defines.svh"
module sipr_top_tb;
  import sipr_pkg::*;
  localparam int FC = 8;
  // stimulus and observed signals
  logic                     clock_i, nrst_i, init_done, host_link, usb_act, pfault, serr, strap;
  sipr_chan_status_t [1:0]  chan_st;
  logic [1:0]               ctrl_tx, ctrl_rx, xcvr_tx, xcvr_rx, bus_dom, alt_dom, alt_tx, alt_rx;
  sipr_led_t                sys_led, ch0_led, ch1_led;
  logic [3:0]               address, byteen;
  logic                     read, write, waitreq, irq;
  logic [31:0]              wdata, rdata, q;
  logic [3:0]               ms, m0, m1;
  logic [4:0]               tbl [9];
  logic [3:0]               expm [9];
  int                       num_errors, checks_done;

  sipr_top #(.FLASH_CYCLES(FC)) dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .init_done_i(init_done), .host_link_i(host_link),
    .usb_active_i(usb_act), .power_fault_i(pfault), .sys_error_i(serr),
    .chan_status_i(chan_st), .route_select_strap_i(strap), .ctrl_tx_i(ctrl_tx),
    .ctrl_rx_o(ctrl_rx), .xcvr_tx_o(xcvr_tx), .xcvr_rx_i(xcvr_rx),
    .chan0_tx_alt_pin_o(alt_tx[0]), .chan0_rx_alt_pin_i(alt_rx[0]),
    .chan1_tx_alt_pin_o(alt_tx[1]), .chan1_rx_alt_pin_i(alt_rx[1]),
    .system_status_led_o(sys_led), .channel0_status_led_o(ch0_led),
    .channel1_status_led_o(ch1_led), .avs_address_i(address), .avs_read_i(read),
    .avs_write_i(write), .avs_writedata_i(wdata), .avs_byteenable_i(byteen),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .irq_o(irq));

  sipr_far_model far (
    .xcvr_tx_i(xcvr_tx), .alt_tx_i(alt_tx), .bus_dom_i(bus_dom), .alt_dom_i(alt_dom),
    .xcvr_rx_o(xcvr_rx), .alt_rx_o(alt_rx));

  // 25 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one avalon transfer; held until waitrequest is seen low at an edge
  task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                          input logic [3:0] be, output logic [31:0] r);
    int n;
    @(posedge clock_i);
    address <= a;
    wdata <= d;
    byteen <= be;
    read <= ~wr;
    write <= wr;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    r = rdata;
    read <= 1'b0;
    write <= 1'b0;
    check("waitrequest answer", 32'(n < 50), 32'h1);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] r);
    bus_xfer(1'b0, a, 32'h0, 4'hF, r);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus_xfer(1'b1, a, d, 4'hF, r);
  endtask

  // record every led value shown over n cycles, one bit per value
  task automatic sample(input int n);
    ms = 4'h0;
    m0 = 4'h0;
    m1 = 4'h0;
    repeat (n) begin
      @(posedge clock_i);
      ms[2'(sys_led)] = 1'b1;
      m0[2'(ch0_led)] = 1'b1;
      m1[2'(ch1_led)] = 1'b1;
    end
  endtask

  task automatic wait_state(input logic [3:0] s);
    int n;
    n = 0;
    do begin
      rd(`SIPR_OFS_STATUS, q);
      n++;
    end while (q[3:0] !== s && n < 100);
    check("system state", 32'(q[3:0]), 32'(s));
  endtask

  task automatic do_reset(input logic s);
    nrst_i <= 1'b0;
    strap <= s;
    repeat (4) @(posedge clock_i);
    check("reset system led", 32'(sys_led), 32'h2);
    check("reset channel leds", {ch1_led, ch0_led}, 32'h0);
    check("reset waitrequest and irq", {waitreq, irq}, 32'h2);
    nrst_i <= 1'b1;
  endtask

  // route follows the strap seen at reset release, not a later change
  task automatic route_check(input logic s);
    ctrl_tx <= 2'b10;
    bus_dom <= 2'b00;
    alt_dom <= 2'b10;
    repeat (3) @(posedge clock_i);
    strap <= ~s;
    repeat (3) @(posedge clock_i);
    check("xcvr_tx", xcvr_tx, s ? 2'b10 : 2'b11);
    check("alt tx", alt_tx, s ? 2'b11 : 2'b10);
    check("ctrl_rx", ctrl_rx, s ? 2'b10 : 2'b00);
    rd(`SIPR_OFS_STATUS, q);
    check("strap status", 32'(q[5:4]), {s, 1'b1});
  endtask

  initial begin
    {init_done, host_link, usb_act, pfault, serr} = 5'h00;
    {read, write, address, wdata, byteen} = 42'h0;
    chan_st = {2{5'b11000}};
    {ctrl_tx, bus_dom, alt_dom} = 6'h30;
    num_errors = 0;
    checks_done = 0;
    // channel cases: {started,connected,ctrl_error,bus_error,overflow}
    tbl = '{5'b10000, 5'b00000, 5'b01000, 5'b01100, 5'b11100,
            5'b11110, 5'b11010, 5'b11001, 5'b11000};
    expm = '{4'h1, 4'h1, 4'h6, 4'h6, 4'h4, 4'h4, 4'h5, 4'h5, 4'h2};
    do_reset(1'b0);
    route_check(1'b0);
    do_reset(1'b1);
    route_check(1'b1);
    // register reset values and access kinds
    rd(`SIPR_OFS_CTRL, q);
    check("ctrl reset", q, 32'h3);
    rd(`SIPR_OFS_IRQ_MASK, q);
    check("mask reset", q, 32'h0);
    wr(4'h2, 32'hFFFF_FFFF);
    rd(4'h2, q);
    check("unmapped read", q, 32'h0);
    wr(`SIPR_OFS_CTRL, 32'h1);
    rd(`SIPR_OFS_CTRL, q);
    check("ctrl write", q, 32'h1);
    // system indicator sequence
    sample(20);
    check("init led", ms, 4'h4);
    init_done <= 1'b1;
    wait_state(4'h2);
    sample(40);
    check("startup flash", ms, 4'h3);
    host_link <= 1'b1;
    wait_state(4'h4);
    sample(40);
    check("linked steady green", ms, 4'h2);
    usb_act <= 1'b1;
    sample(40);
    check("usb traffic flash", ms, 4'h3);
    usb_act <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      pfault <= (k == 0);
      serr <= (k == 1);
      repeat (3) @(posedge clock_i);
      check("fault led off", 32'(sys_led), 32'h0);
      wait_state(4'h8);
      pfault <= 1'b0;
      serr <= 1'b0;
      wait_state(4'h4);
    end
    rd(`SIPR_OFS_IRQ_STAT, q);
    check("fault and link events", q, 32'h30);
    wr(`SIPR_OFS_IRQ_STAT, 32'h30);
    rd(`SIPR_OFS_IRQ_STAT, q);
    check("events cleared", q, 32'h0);
    // channel decode and precedence, each channel a different case
    for (int i = 0; i < 9; i++) begin
      chan_st[0] <= tbl[i];
      chan_st[1] <= tbl[(i + 1) % 9];
      repeat (3) @(posedge clock_i);
      sample(40);
      check("channel0 led", m0, expm[i]);
      check("channel1 led", m1, expm[(i + 1) % 9]);
    end
    // interrupt: masked, unmasked, cleared
    rd(`SIPR_OFS_IRQ_STAT, q);
    check("channel events", q, 32'h0F);
    check("irq masked", 32'(irq), 32'h0);
    wr(`SIPR_OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clock_i);
    check("irq raised", 32'(irq), 32'h1);
    wr(`SIPR_OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clock_i);
    check("irq cleared", 32'(irq), 32'h0);
    bus_xfer(1'b1, `SIPR_OFS_IRQ_MASK, 32'h3F, 4'h0, q);
    rd(`SIPR_OFS_IRQ_MASK, q);
    check("byteenable off write", q, 32'h1);
    tally_and_finish();
  end

  // watchdog well past the expected run of under a thousand cycles
  initial begin
    #(40 * 40000);
    num_errors++;
    tally_and_finish();
  end
endmodule
